// ### hdl/ids_pkg.sv
package ids_pkg;

	// Register byte offsets on the bus.
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_KEYS     = 8'h04;
	localparam logic [7:0] REG_STATUS   = 8'h08;
	localparam logic [7:0] REG_IDENT    = 8'h0c;
	localparam logic [7:0] REG_INTCODE  = 8'h10;
	localparam logic [7:0] REG_PAGESTAT = 8'h14;
	localparam logic [7:0] REG_SOURCES  = 8'h18;

	// Control register fields and reset value.
	localparam int         CTRL_STOP_BIT   = 0;
	localparam int         CTRL_PAGING_BIT = 1;
	localparam logic [1:0] CTRL_RESET      = 2'h0;

	// Keys register fields.
	localparam int KEY_SET_INBOUND    = 0;
	localparam int KEY_SET_OUTBOUND   = 1;
	localparam int KEY_CLEAR_OUTBOUND = 2;

	// Interrupt group positions, lowest priority first.
	localparam int GEN_CONSOLE = 0;
	localparam int GEN_INBOUND = 1;
	localparam int GEN_SERIAL  = 2;
	localparam int GEN_XFER    = 3;
	localparam int GEN_ZERO    = 4;
	localparam int GEN_PARITY  = 5;
	localparam int GEN_RANGE   = 6;
	localparam int GEN_SUPPLY  = 7;

	// Panel group positions.
	localparam int PAN_RUN   = 0;
	localparam int PAN_TICK  = 2;
	localparam int PAN_CLEAR = 7;

	// Internal interrupt codes; octal 10, 11 and 12 are 8, 9 and 10.
	localparam logic [3:0] IIC_NONE       = 4'h0;
	localparam logic [3:0] IIC_SVC        = 4'h1;
	localparam logic [3:0] IIC_PROTECT    = 4'h2;
	localparam logic [3:0] IIC_PAGE       = 4'h3;
	localparam logic [3:0] IIC_ILLEGAL    = 4'h4;
	localparam logic [3:0] IIC_ERRFLAG    = 4'h5;
	localparam logic [3:0] IIC_PRIV       = 4'h6;
	localparam logic [3:0] IIC_IOERR      = 4'h7;
	localparam logic [3:0] IIC_PARITY     = 4'h8;
	localparam logic [3:0] IIC_RANGE      = 4'h9;
	localparam logic [3:0] IIC_SUPPLY     = 4'ha;
	localparam logic [3:0] LEVEL_INTERNAL = 4'he;

	// Internal bus source decodes from the microcode field.
	localparam logic [4:0] SRC_GENERAL_IDENT = 5'h01;
	localparam logic [4:0] SRC_CONSOLE_IDENT = 5'h02;
	localparam logic [4:0] SRC_INTCODE       = 5'h03;

	// Vector bases, arbitrary placement in the microcode space.
	localparam logic [11:0] CONSOLE_VECTOR_BASE = 12'h100;
	localparam logic [11:0] GENERAL_VECTOR_BASE = 12'h110;

	// Periodic tick.
	localparam int TICK_PERIOD_US = 20000;
	localparam int CLK_MHZ        = 25;
	localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_MHZ;

	typedef struct packed {
		logic       cpuClearInbound;
		logic       cpuResetInbound;
		logic       cpuSetOutbound;
		logic       intAck;
		logic       srcValid;
		logic [4:0] srcSel;
	} ids_ucode_cmd_t;

	typedef struct packed {
		logic       supervisorCallInstr;
		logic [7:0] supervisorCode;
		logic       protectViolation;
		logic       pageFault;
		logic [7:0] pagingCause;
		logic       illegalInstr;
		logic       privilegedInstr;
		logic       ioInstrError;
		logic       watchdogTimeout;
	} ids_internal_ev_t;

endpackage

// ### hdl/ids_box.sv
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module ids_box #(
	parameter int TickCycles = ids_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic                      clk,
	input  wire logic                      reset,
	// AHB-Lite slave.
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic      [31:0]               hrdata,
	output logic                           hreadyout,
	output logic                           hresp,
	// Interrupt sources from the board.
	input  wire logic                      consoleInt,
	input  wire logic                      serialCtrlInt,
	input  wire logic                      xferCtrlInt,
	input  wire logic                      zeroFlag,
	input  wire logic                      parityErrorFlag,
	input  wire logic                      rangeErrorFlag,
	input  wire logic                      refreshCycle,
	input  wire logic                      boardSupplyFail,
	input  wire logic                      runStatus,
	// Pins from outside the clock domain.
	input  wire logic                      hostSupplyFail,
	input  wire logic                      masterClearSwitch,
	// Microcode side.
	input  wire ids_pkg::ids_ucode_cmd_t   ucodeCmd,
	input  wire ids_pkg::ids_internal_ev_t internalEv,
	output logic      [15:0]               idbData,
	output logic      [11:0]               vectorAddr,
	output logic                           interruptPending,
	output logic                           level14Req,
	output logic      [7:0]                level14T,
	// Host side.
	output logic                           hostIrq5
);

	logic [1:0]  ctrl;
	logic        hostToCpuFlag;
	logic        cpuToHostFlag;
	logic        interruptPendingFf;
	logic [3:0]  intCode;
	logic [7:0]  pagingStatus;
	logic        tickFlag;
	logic [31:0] tickCount;
	logic [1:0]  syncA;
	logic [1:0]  syncB;
	logic [1:0]  syncC;
	logic [1:0]  pinLevel;
	logic [3:0]  prevLevels;
	logic        dataPhase;
	logic        dataWrite;
	logic [7:0]  dataAddr;
	logic [7:0]  intGroup;
	logic [7:0]  panelGroup;
	logic        generalRequest;
	logic        consoleGroupRequest;
	logic        gatedConsoleRequest;
	logic [2:0]  generalIdent;
	logic [2:0]  consoleIdent;
	logic        keyLoadStrobe;
	logic        codeReadBus;
	logic        codeReadUcode;
	logic        supplySource;
	logic [3:0]  next_intCode;
	logic        stopMode;
	logic        pagingEnable;

	assign stopMode     = ctrl[ids_pkg::CTRL_STOP_BIT];
	assign pagingEnable = ctrl[ids_pkg::CTRL_PAGING_BIT];

	function automatic logic [2:0] highest(input logic [7:0] grp);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (grp[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncA    <= 2'h0;
			syncB    <= 2'h0;
			syncC    <= 2'h0;
			pinLevel <= 2'h0;
		end else begin
			syncA <= {masterClearSwitch, hostSupplyFail};
			syncB <= syncA;
			syncC <= syncB;
			for (int i = 0; i < 2; i++) begin
				if (syncB[i] == syncC[i]) begin
					pinLevel[i] <= syncC[i];
				end
			end
		end
	end

	assign supplySource = boardSupplyFail | pinLevel[0] | internalEv.watchdogTimeout;
	always_comb begin
		intGroup                       = 8'h00;
		intGroup[ids_pkg::GEN_CONSOLE] = consoleInt;
		intGroup[ids_pkg::GEN_INBOUND] = hostToCpuFlag;
		intGroup[ids_pkg::GEN_SERIAL]  = serialCtrlInt;
		intGroup[ids_pkg::GEN_XFER]    = xferCtrlInt;
		intGroup[ids_pkg::GEN_ZERO]    = zeroFlag;
		intGroup[ids_pkg::GEN_PARITY]  = parityErrorFlag;
		intGroup[ids_pkg::GEN_RANGE]   = rangeErrorFlag & ~refreshCycle;
		intGroup[ids_pkg::GEN_SUPPLY]  = supplySource;
	end
	always_comb begin
		panelGroup                     = 8'h00;
		panelGroup[ids_pkg::PAN_RUN]   = ~runStatus;
		panelGroup[ids_pkg::PAN_TICK]  = tickFlag;
		panelGroup[ids_pkg::PAN_CLEAR] = pinLevel[1];
	end

	assign generalRequest      = |intGroup;
	assign consoleGroupRequest = |panelGroup;
	assign gatedConsoleRequest = consoleGroupRequest & ~stopMode;
	assign generalIdent        = highest(intGroup);
	assign consoleIdent        = highest(panelGroup);
	assign codeReadUcode       = ucodeCmd.srcValid && (ucodeCmd.srcSel == ids_pkg::SRC_INTCODE);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tickCount <= 32'h0;
			tickFlag  <= 1'b0;
		end else begin
			if (tickCount == 32'(TickCycles - 1)) begin
				tickCount <= 32'h0;
				tickFlag  <= 1'b1;
			end else begin
				tickCount <= tickCount + 32'h1;
				if (ucodeCmd.srcValid && ucodeCmd.srcSel == ids_pkg::SRC_CONSOLE_IDENT
				    && consoleIdent == 3'(ids_pkg::PAN_TICK)) begin
					tickFlag <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			interruptPendingFf <= 1'b0;
		end else if (generalRequest || gatedConsoleRequest) begin
			interruptPendingFf <= 1'b1;
		end else if (ucodeCmd.intAck) begin
			interruptPendingFf <= 1'b0;
		end
	end

	assign interruptPending = interruptPendingFf;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vectorAddr <= 12'h000;
			idbData    <= 16'h0000;
		end else begin
			if (gatedConsoleRequest) begin
				vectorAddr <= ids_pkg::CONSOLE_VECTOR_BASE + 12'(consoleIdent);
			end else if (interruptPendingFf) begin
				vectorAddr <= ids_pkg::GENERAL_VECTOR_BASE + 12'(generalIdent);
			end
			case (ucodeCmd.srcSel)
				ids_pkg::SRC_GENERAL_IDENT: idbData <= {13'h0, generalIdent};
				ids_pkg::SRC_CONSOLE_IDENT: idbData <= {13'h0, consoleIdent};
				ids_pkg::SRC_INTCODE:       idbData <= {4'h0, level14T, intCode};
				default:                    idbData <= 16'h0000;
			endcase
		end
	end

	// Signal box flags; a set in the same cycle as a clear wins.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hostToCpuFlag <= 1'b0;
			cpuToHostFlag <= 1'b0;
		end else begin
			if ((keyLoadStrobe && hwdata[ids_pkg::KEY_SET_INBOUND]) || ucodeCmd.cpuResetInbound) begin
				hostToCpuFlag <= 1'b1;
			end else if (ucodeCmd.cpuClearInbound) begin
				hostToCpuFlag <= 1'b0;
			end
			if (ucodeCmd.cpuSetOutbound || (keyLoadStrobe && hwdata[ids_pkg::KEY_SET_OUTBOUND])) begin
				cpuToHostFlag <= 1'b1;
			end else if (keyLoadStrobe && hwdata[ids_pkg::KEY_CLEAR_OUTBOUND]) begin
				cpuToHostFlag <= 1'b0;
			end
		end
	end

	assign hostIrq5 = cpuToHostFlag;

	always_comb begin
		next_intCode = ids_pkg::IIC_NONE;
		if (internalEv.supervisorCallInstr) next_intCode = ids_pkg::IIC_SVC;
		if (internalEv.protectViolation && pagingEnable) next_intCode = ids_pkg::IIC_PROTECT;
		if (internalEv.pageFault && pagingEnable) next_intCode = ids_pkg::IIC_PAGE;
		if (internalEv.illegalInstr) next_intCode = ids_pkg::IIC_ILLEGAL;
		if (zeroFlag && !prevLevels[0]) next_intCode = ids_pkg::IIC_ERRFLAG;
		if (internalEv.privilegedInstr && pagingEnable) next_intCode = ids_pkg::IIC_PRIV;
		if (internalEv.ioInstrError) next_intCode = ids_pkg::IIC_IOERR;
		if (parityErrorFlag && !prevLevels[1]) next_intCode = ids_pkg::IIC_PARITY;
		if (intGroup[ids_pkg::GEN_RANGE] && !prevLevels[2]) next_intCode = ids_pkg::IIC_RANGE;
		if (supplySource && !prevLevels[3]) next_intCode = ids_pkg::IIC_SUPPLY;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prevLevels   <= 4'h0;
			intCode      <= ids_pkg::IIC_NONE;
			level14Req   <= 1'b0;
			level14T     <= 8'h00;
			pagingStatus <= 8'h00;
		end else begin
			prevLevels <= {supplySource, intGroup[ids_pkg::GEN_RANGE], parityErrorFlag, zeroFlag};
			if (next_intCode != ids_pkg::IIC_NONE) begin
				intCode    <= next_intCode;
				level14Req <= 1'b1;
			end else if (codeReadBus || codeReadUcode) begin
				level14Req <= 1'b0;
			end
			if (internalEv.supervisorCallInstr) begin
				level14T <= internalEv.supervisorCode;
			end
			if (pagingEnable && (internalEv.protectViolation || internalEv.pageFault)) begin
				pagingStatus <= internalEv.pagingCause;
			end
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dataPhase <= 1'b0;
			dataWrite <= 1'b0;
			dataAddr  <= 8'h00;
		end else if (hready) begin
			dataPhase <= hsel && htrans[1];
			dataWrite <= hwrite;
			dataAddr  <= {haddr[7:2], 2'h0};
		end
	end

	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign keyLoadStrobe = dataPhase && dataWrite && dataAddr == ids_pkg::REG_KEYS;
	assign codeReadBus   = hready && hsel && htrans[1] && !hwrite && {haddr[7:2], 2'h0} == ids_pkg::REG_INTCODE;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl <= ids_pkg::CTRL_RESET;
		end else if (dataPhase && dataWrite && dataAddr == ids_pkg::REG_CTRL) begin
			ctrl <= hwdata[1:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case ({haddr[7:2], 2'h0})
				ids_pkg::REG_CTRL:     hrdata <= {30'h0, ctrl};
				ids_pkg::REG_STATUS:   hrdata <= {26'h0, level14Req, gatedConsoleRequest, interruptPendingFf,
				                                  hostIrq5, cpuToHostFlag, hostToCpuFlag};
				ids_pkg::REG_IDENT:    hrdata <= {25'h0, consoleIdent, 1'b0, generalIdent};
				ids_pkg::REG_INTCODE:  hrdata <= {16'h0, ids_pkg::LEVEL_INTERNAL, level14T, intCode};
				ids_pkg::REG_PAGESTAT: hrdata <= {24'h0, pagingStatus};
				ids_pkg::REG_SOURCES:  hrdata <= {16'h0, panelGroup, intGroup};
				default:               hrdata <= 32'h0;
			endcase
		end else if (hready) begin
			hrdata <= 32'h0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_clearOutbound;
		keyLoadStrobe && hwdata[ids_pkg::KEY_CLEAR_OUTBOUND] && !hwdata[ids_pkg::KEY_SET_OUTBOUND]
		&& !ucodeCmd.cpuSetOutbound;
	endsequence

	sequence s_outboundLow;
		!cpuToHostFlag && !hostIrq5;
	endsequence

	property p_rangeRefresh;
		refreshCycle |-> !intGroup[ids_pkg::GEN_RANGE];
	endproperty
	a_rangeRefresh: assert property (p_rangeRefresh) else $error("Range source active in refresh.");

	property p_stopGate;
		stopMode |-> !gatedConsoleRequest;
	endproperty
	a_stopGate: assert property (p_stopGate) else $error("Console request passed while stopped.");

	property p_pendSet;
		(generalRequest || gatedConsoleRequest) |=> interruptPending;
	endproperty
	a_pendSet: assert property (p_pendSet) else $error("Pending flip-flop not set.");

	property p_inboundClear;
		ucodeCmd.cpuClearInbound && !ucodeCmd.cpuResetInbound && !keyLoadStrobe |=> !hostToCpuFlag;
	endproperty
	a_inboundClear: assert property (p_inboundClear) else $error("Inbound flag not cleared.");

	property p_inboundSource;
		$rose(hostToCpuFlag) |-> $past(keyLoadStrobe || ucodeCmd.cpuResetInbound);
	endproperty
	a_inboundSource: assert property (p_inboundSource) else $error("Inbound flag set from wrong end.");

	property p_outboundSet;
		ucodeCmd.cpuSetOutbound |=> cpuToHostFlag ##0 hostIrq5;
	endproperty
	a_outboundSet: assert property (p_outboundSet) else $error("Outbound request not raised.");

	property p_outboundClear;
		s_clearOutbound |=> s_outboundLow;
	endproperty
	a_outboundClear: assert property (p_outboundClear) else $error("Outbound request not dropped.");

	property p_pagingGate;
		$rose(level14Req) && intCode == ids_pkg::IIC_PAGE |-> $past(pagingEnable);
	endproperty
	a_pagingGate: assert property (p_pagingGate) else $error("Page fault reported with paging off.");

	property p_svcCode;
		internalEv.supervisorCallInstr |=> level14T == $past(internalEv.supervisorCode) && level14Req;
	endproperty
	a_svcCode: assert property (p_svcCode) else $error("Supervisor code not loaded.");

	property p_vector;
		gatedConsoleRequest && !reset |=> vectorAddr == ids_pkg::CONSOLE_VECTOR_BASE + 12'($past(consoleIdent));
	endproperty
	a_vector: assert property (p_vector) else $error("Console vector wrong.");

endmodule

// ### bench/ids_ucode_model.sv
`timescale 1ns/1ps
module ids_ucode_model (
	// Clock.
	input  wire logic               clk,
	// Command decodes to the box.
	output ids_pkg::ids_ucode_cmd_t ucodeCmd
);
	initial ucodeCmd = '0;

	// Drives one command decode for exactly one cycle, then idles the bus.
	task automatic send(input ids_pkg::ids_ucode_cmd_t cmd);
		@(posedge clk);
		ucodeCmd <= cmd;
		@(posedge clk);
		ucodeCmd <= '0;
	endtask

	// Clears the inbound flag, then re-sets it after a gap if more work was found.
	task automatic serviceInbound(input logic more, input int gap);
		send(10'h200);
		if (more) begin
			repeat (gap) @(posedge clk);
			send(10'h100);
		end
	endtask
endmodule

// ### bench/irq_detect_and_signal_box_tb.sv
`timescale 1ns/1ps
module irq_detect_and_signal_box_tb;
	localparam int Tick = 16;
	logic                      clk, reset, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]               haddr, hwdata, hrdata, rd;
	logic [1:0]                htrans;
	logic [2:0]                hsize, id;
	logic [7:0]                gen, m, ex, cause, level14T, lastT;
	logic                      refreshCycle, runStatus, hostSupplyFail, masterClearSwitch;
	logic [15:0]               idbData;
	logic [11:0]               vectorAddr;
	logic                      interruptPending, level14Req, hostIrq5;
	logic [3:0]                codes [12];
	ids_pkg::ids_ucode_cmd_t   ucodeCmd;
	ids_pkg::ids_internal_ev_t internalEv;
	int                        errors, checked, cycles;

	assign hready = hreadyout;

	ids_box #(.TickCycles(Tick)) u_dut (
		.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .consoleInt(gen[0]), .serialCtrlInt(gen[2]), .xferCtrlInt(gen[3]),
		.zeroFlag(gen[4]), .parityErrorFlag(gen[5]), .rangeErrorFlag(gen[6]), .refreshCycle(refreshCycle),
		.boardSupplyFail(gen[7]), .runStatus(runStatus), .hostSupplyFail(hostSupplyFail),
		.masterClearSwitch(masterClearSwitch), .ucodeCmd(ucodeCmd), .internalEv(internalEv),
		.idbData(idbData), .vectorAddr(vectorAddr), .interruptPending(interruptPending),
		.level14Req(level14Req), .level14T(level14T), .hostIrq5(hostIrq5)
	);

	ids_ucode_model u_ucode (
		.clk(clk),
		.ucodeCmd(ucodeCmd)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Waits for hready under a bounded count.
	task automatic waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) errors++;
	endtask

	// One single-word transfer; read data is taken at the edge ending the data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		waitReady();
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		waitReady();
		rd = hrdata;
	endtask

	function automatic logic [2:0] topBit(input logic [7:0] v);
		topBit = 3'h0;
		for (int b = 0; b < 8; b++) if (v[b]) topBit = 3'(b);
	endfunction

	function automatic ids_pkg::ids_ucode_cmd_t op(input logic [4:0] bits, input logic [4:0] sel);
		op = {bits, sel};
	endfunction

	initial begin
		void'($urandom(32'h13ec02f2));
		codes = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'ha, 4'ha};
		{reset, hsel, hwrite, refreshCycle, hostSupplyFail, masterClearSwitch} = 6'h20;
		{haddr, hwdata, htrans, gen, lastT} = '0;
		hsize = 3'h2;
		runStatus = 1'b1;
		internalEv = '0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		bus(0, ids_pkg::REG_STATUS, 0); check("status", rd, 0);
		bus(0, ids_pkg::REG_CTRL, 0); check("ctrl", rd, 0);
		check("hresp", hresp, 1'b0);
		bus(1, 8'h1c, 32'hffffffff);
		bus(0, 8'h1c, 0); check("unmapped", rd, 0);
		// Interrupt group ranking, with the console group held off by stop mode.
		bus(1, ids_pkg::REG_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			m = (i == 0) ? 8'h01 : (i == 1) ? 8'hfd : (8'($urandom()) & 8'hfd) | 8'h01;
			@(posedge clk);
			gen <= m;
			refreshCycle <= i[0];
			idle(4);
			ex = i[0] ? (m & 8'hbf) : m;
			id = topBit(ex);
			check("pending", interruptPending, 1'b1);
			check("vector", vectorAddr, ids_pkg::GENERAL_VECTOR_BASE + {9'h0, id});
			bus(0, ids_pkg::REG_SOURCES, 0); check("sources", rd[7:0], ex);
			bus(0, ids_pkg::REG_IDENT, 0); check("ident", rd[2:0], id);
			u_ucode.send(op(5'h01, ids_pkg::SRC_GENERAL_IDENT)); #1; check("idb", idbData, {13'h0, id});
		end
		@(posedge clk);
		gen <= 8'h0;
		refreshCycle <= 1'b0;
		idle(4);
		u_ucode.send(op(5'h02, 5'h0)); #1; check("ack", interruptPending, 1'b0);
		// Panel group and its stop-mode gate.
		bus(1, ids_pkg::REG_CTRL, 32'h0);
		runStatus <= 1'b0;
		idle(4);
		bus(0, ids_pkg::REG_SOURCES, 0); check("stop src", rd[8 + ids_pkg::PAN_RUN], 1'b1);
		bus(0, ids_pkg::REG_STATUS, 0); check("gated", rd[4], 1'b1);
		bus(1, ids_pkg::REG_CTRL, 32'h1);
		bus(0, ids_pkg::REG_STATUS, 0); check("gated stop", rd[4], 1'b0);
		bus(1, ids_pkg::REG_CTRL, 32'h0);
		masterClearSwitch <= 1'b1;
		idle(8);
		check("console vector", vectorAddr, ids_pkg::CONSOLE_VECTOR_BASE + 12'h7);
		bus(0, ids_pkg::REG_IDENT, 0); check("clear ident", rd[6:4], 3'h7);
		u_ucode.send(op(5'h01, ids_pkg::SRC_CONSOLE_IDENT)); #1; check("idb console", idbData, 16'h7);
		@(posedge clk);
		masterClearSwitch <= 1'b0;
		runStatus <= 1'b1;
		idle(2 * Tick + 8);
		bus(0, ids_pkg::REG_IDENT, 0); check("tick ident", rd[6:4], 3'h2);
		// Signal box, both directions.
		bus(1, ids_pkg::REG_KEYS, 32'h1);
		bus(0, ids_pkg::REG_STATUS, 0); check("in flag", rd[0], 1'b1);
		bus(0, ids_pkg::REG_SOURCES, 0); check("in src", rd[ids_pkg::GEN_INBOUND], 1'b1);
		bus(1, ids_pkg::REG_KEYS, 32'h4);
		bus(0, ids_pkg::REG_STATUS, 0); check("in kept", rd[0], 1'b1);
		u_ucode.serviceInbound(1'b1, 3);
		bus(0, ids_pkg::REG_STATUS, 0); check("in reset", rd[0], 1'b1);
		u_ucode.serviceInbound(1'b0, 0);
		bus(0, ids_pkg::REG_STATUS, 0); check("in clear", rd[0], 1'b0);
		u_ucode.send(op(5'h04, 5'h0)); #1; check("irq5", hostIrq5, 1'b1);
		bus(0, ids_pkg::REG_STATUS, 0); check("out status", rd[2:1], 2'h3);
		u_ucode.send(op(5'h10, 5'h0));
		bus(0, ids_pkg::REG_STATUS, 0); check("out kept", rd[1], 1'b1);
		bus(1, ids_pkg::REG_KEYS, 32'h4); #1; check("irq5 clear", hostIrq5, 1'b0);
		bus(0, ids_pkg::REG_STATUS, 0); check("out clear", rd[2:1], 2'h0);
		bus(1, ids_pkg::REG_KEYS, 32'h2); #1; check("irq5 host", hostIrq5, 1'b1);
		bus(1, ids_pkg::REG_KEYS, 32'h4);
		u_ucode.send(op(5'h04, 5'h0)); #1; check("irq5 again", hostIrq5, 1'b1);
		// Internal interrupt codes on level 14.
		bus(0, ids_pkg::REG_INTCODE, 0);
		@(posedge clk);
		internalEv.protectViolation <= 1'b1;
		@(posedge clk);
		internalEv <= '0;
		idle(3);
		check("protect off", level14Req, 1'b0);
		bus(1, ids_pkg::REG_CTRL, 32'h2);
		for (int k = 0; k < 12; k++) begin
			cause = 8'($urandom());
			if (k == 0) lastT = cause;
			@(posedge clk);
			case (k)
				0: internalEv.supervisorCallInstr <= 1'b1;
				1: internalEv.protectViolation <= 1'b1;
				2: internalEv.pageFault <= 1'b1;
				3: internalEv.illegalInstr <= 1'b1;
				5: internalEv.privilegedInstr <= 1'b1;
				6: internalEv.ioInstrError <= 1'b1;
				10: hostSupplyFail <= 1'b1;
				11: internalEv.watchdogTimeout <= 1'b1;
				default: gen <= 8'h01 << ((k == 4) ? 4 : k - 2);
			endcase
			internalEv.supervisorCode <= cause;
			internalEv.pagingCause <= cause;
			@(posedge clk);
			internalEv <= '0;
			gen <= 8'h0;
			@(posedge clk);
			hostSupplyFail <= 1'b0;
			idle(6);
			check("l14 req", level14Req, 1'b1);
			check("l14 t", level14T, lastT);
			if (k == 11) begin
				u_ucode.send(op(5'h01, ids_pkg::SRC_INTCODE)); #1;
				check("idb code", idbData, {4'h0, lastT, codes[k]});
			end else begin
				bus(0, ids_pkg::REG_INTCODE, 0); #1;
				check("code", rd, {16'h0, ids_pkg::LEVEL_INTERNAL, lastT, codes[k]});
			end
			check("l14 clear", level14Req, 1'b0);
			if (k == 1 || k == 2) begin
				bus(0, ids_pkg::REG_PAGESTAT, 0); check("cause", rd, {24'h0, cause});
			end
		end
		// Reset in mid-run with both flags and the pending flip-flop set.
		bus(1, ids_pkg::REG_KEYS, 32'h1);
		@(posedge clk);
		reset <= 1'b1;
		idle(2);
		check("rst irq5", hostIrq5, 1'b0);
		check("rst pending", interruptPending, 1'b0);
		@(posedge clk);
		reset <= 1'b0;
		bus(0, ids_pkg::REG_STATUS, 0); check("rst status", rd, 0);
		report_and_stop();
	end
endmodule
